// File: rtl/pjdc_defs.svh
`ifndef PJDC_DEFS_SVH
`define PJDC_DEFS_SVH
// register byte offsets
`define PJDC_OFF_CMD      12'h000
`define PJDC_OFF_VALUE    12'h004
`define PJDC_OFF_VALUE2   12'h008
`define PJDC_OFF_CFG      12'h00c
`define PJDC_OFF_ROT_END  12'h010
`define PJDC_OFF_SWL_LO   12'h014
`define PJDC_OFF_SWL_HI   12'h018
`define PJDC_OFF_ERR      12'h01c
`define PJDC_OFF_IRQ_STAT 12'h020
`define PJDC_OFF_IRQ_EN   12'h024
`define PJDC_OFF_IRQ_CLR  12'h028
`define PJDC_OFF_ZERO_OFS 12'h02c
`define PJDC_OFF_SWITCH   12'h030
`define PJDC_OFF_SYS_STAT 12'h034
// cfg field positions
`define PJDC_CFG_ROTARY   0
`define PJDC_CFG_COARSE   1
`define PJDC_CFG_SSI      2
`define PJDC_CFG_SYNC     3
`define PJDC_CFG_MD_NEW   4
// range limits in micrometres
`define PJDC_RANGE_FINE   32'sd100000000
`define PJDC_RANGE_COARSE 32'sd1000000000
// error class and numbers
`define PJDC_ERR_CLASS    8'h04
`define PJDC_E_INCR       8'h06
`define PJDC_E_ZERO       8'h0a
`define PJDC_E_COORD      8'h0b
`define PJDC_E_REFPT      8'h0c
`define PJDC_E_MD_ACT     8'h14
`define PJDC_E_BITSET     8'h1b
`define PJDC_E_BITCODE    8'h1d
`define PJDC_E_CANCEL     8'h22
`define PJDC_E_VAL36      8'h24
`define PJDC_E_VAL37      8'h25
`define PJDC_E_NO_MD      8'h6b
`define PJDC_E_NO_SYNC    8'h6c
// reset values
`define PJDC_RST_SWL_LO   32'hfa0a1f00
`define PJDC_RST_SWL_HI   32'h05f5e100
`define PJDC_RST_ROT_END  32'h00000168
`endif

// File: rtl/pjdc_pkg.sv
package pjdc_pkg;
  typedef enum logic [3:0] {
    PJDC_CMD_NONE     = 4'b0000,
    PJDC_CMD_TARGET   = 4'b0001,
    PJDC_CMD_INCR     = 4'b0010,
    PJDC_CMD_ZERO_OFS = 4'b0011,
    PJDC_CMD_COORD    = 4'b0100,
    PJDC_CMD_REFPT    = 4'b0101,
    PJDC_CMD_MD_ACT   = 4'b0110,
    PJDC_CMD_BITSET   = 4'b0111,
    PJDC_CMD_BITCODE  = 4'b1000,
    PJDC_CMD_CANCEL   = 4'b1001,
    PJDC_CMD_SET_ACT  = 4'b1010,
    PJDC_CMD_SET_FLY  = 4'b1011,
    PJDC_CMD_SWITCH   = 4'b1100,
    PJDC_CMD_VAL36    = 4'b1101
  } pjdc_cmd_t;
  typedef struct packed {
    logic rotary;
    logic coarse;
    logic ssi;
    logic synced;
    logic md_new;
  } pjdc_cfg_t;
  typedef struct packed {
    logic [7:0] err_class;
    logic [7:0] err_num;
  } pjdc_err_t;
endpackage : pjdc_pkg

// File: rtl/pjdc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pjdc_defs.svh"
// Overview of operation
// - check each job on arrival; rejections are data error class 4
// - data errors never stop motion nor raise diagnostic interrupts
// - error 6: increment/target outside range, or rotary value negative or not below end
// - error 10: zero offset magnitude beyond 100 m or 1000 m
// - error 10: offset would push a limit switch outside travel range
// - error 10: rotary zero offset greater than rotary axis end
// - errors 11/12: linear coordinate outside shifted limit switches
// - errors 11/12: rotary coordinate negative or above axis end
// - error 20: activate machine data with no new clean set
// - errors 27/29: unused unwritten bits not zero
// - error 34: cancel set actual value leaves working range, checked only on a linear ssi axis
// - errors 36/37: value outside range; 36 also for bad rotary
// - error 37: switch-off difference not below switchover difference
// - error 107: job needs machine data that was never activated, or is now both missing and inactive
// - error 108: set actual value while axis not synchronized
// - operator error while changing controls ends current positioning
module pjdc_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_md_present,
  input wire logic i_md_active,
  input wire logic i_operator_err,
  input wire logic i_ctrl_change,
  input wire logic [31:0] i_actual_pos,
  output logic o_pos_abort,
  output logic o_irq
);
  logic wr_en;
  logic rd_en;
  logic [31:0] value_q;
  logic [31:0] value2_q;
  logic [31:0] rot_end_q;
  logic [31:0] swl_lo_q;
  logic [31:0] swl_hi_q;
  logic [31:0] zero_ofs_q;
  logic [31:0] target_q;
  logic [31:0] coord_q;
  logic [31:0] bits_q;
  logic [31:0] sw_off_q;
  logic [31:0] sw_over_q;
  logic [31:0] act_q;
  pjdc_pkg::pjdc_cfg_t cfg_q;
  pjdc_pkg::pjdc_err_t err_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_en_q;
  logic abort_q;
  logic md_activated_q;
  logic job_go;
  pjdc_pkg::pjdc_cmd_t job_cmd;
  logic [7:0] err_num_d;
  logic [2:0] irq_set;

  // one-wait-free apb slave: every access ends in its first access cycle
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & i_penable & ~i_pwrite;
  assign o_pready = 1'b1;
  assign job_go = wr_en && (i_paddr == `PJDC_OFF_CMD);
  assign job_cmd = pjdc_pkg::pjdc_cmd_t'(i_pwdata[3:0]);

  // true when v lies outside plus/minus the range for the resolution
  function automatic logic out_of_range(input logic [31:0] v,
                                        input logic coarse);
    logic signed [31:0] s;
    logic signed [31:0] lim;
    s = $signed(v);
    lim = coarse ? `PJDC_RANGE_COARSE : `PJDC_RANGE_FINE;
    out_of_range = (s > lim) || (s < -lim);
  endfunction : out_of_range

  // rotary value must be non-negative; strict says end itself is illegal
  function automatic logic bad_rotary(input logic [31:0] v,
                                      input logic [31:0] rend,
                                      input logic strict);
    bad_rotary = $signed(v) < 0 ||
                 (strict ? ($signed(v) >= $signed(rend))
                         : ($signed(v) > $signed(rend)));
  endfunction : bad_rotary

  // linear value outside the offset-shifted limit switches
  function automatic logic outside_limits(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi,
                                          input logic [31:0] ofs);
    logic signed [32:0] sv;
    sv = $signed({v[31], v});
    outside_limits = sv < ($signed({lo[31], lo}) - $signed({ofs[31], ofs}))
                  || sv > ($signed({hi[31], hi}) - $signed({ofs[31], ofs}));
  endfunction : outside_limits

  // evaluate the job against current settings in the same cycle
  always_comb
  begin
    logic signed [32:0] nlo;
    logic signed [32:0] nhi;
    logic signed [32:0] lim;
    nlo = 33'sd0;
    nhi = 33'sd0;
    lim = cfg_q.coarse ? 33'sd1000000000 : 33'sd100000000;
    err_num_d = 8'h00;
    case (job_cmd)
      pjdc_pkg::PJDC_CMD_TARGET,
      pjdc_pkg::PJDC_CMD_INCR:
      begin
        if (!md_activated_q)
          err_num_d = `PJDC_E_NO_MD;
        else if (out_of_range(value_q, cfg_q.coarse) ||
                 (cfg_q.rotary && bad_rotary(value_q, rot_end_q, 1'b1)))
          err_num_d = `PJDC_E_INCR;
      end
      pjdc_pkg::PJDC_CMD_ZERO_OFS:
      begin
        nlo = $signed({swl_lo_q[31], swl_lo_q}) -
              $signed({value_q[31], value_q});
        nhi = $signed({swl_hi_q[31], swl_hi_q}) -
              $signed({value_q[31], value_q});
        if (!md_activated_q)
          err_num_d = `PJDC_E_NO_MD;
        else if (out_of_range(value_q, cfg_q.coarse))
          err_num_d = `PJDC_E_ZERO;
        else if (cfg_q.rotary && $signed(value_q) > $signed(rot_end_q))
          err_num_d = `PJDC_E_ZERO;
        else if (!cfg_q.rotary &&
                 (nlo < -lim || nlo > lim || nhi < -lim || nhi > lim))
          err_num_d = `PJDC_E_ZERO;
      end
      pjdc_pkg::PJDC_CMD_COORD,
      pjdc_pkg::PJDC_CMD_REFPT:
      begin
        if (!md_activated_q)
          err_num_d = `PJDC_E_NO_MD;
        else if (cfg_q.rotary ? bad_rotary(value_q, rot_end_q, 1'b0)
                 : outside_limits(value_q, swl_lo_q, swl_hi_q, zero_ofs_q))
          err_num_d = (job_cmd == pjdc_pkg::PJDC_CMD_COORD) ?
                      `PJDC_E_COORD : `PJDC_E_REFPT;
      end
      pjdc_pkg::PJDC_CMD_MD_ACT:
      begin
        if (!cfg_q.md_new || !i_md_present)
          err_num_d = `PJDC_E_MD_ACT;
      end
      pjdc_pkg::PJDC_CMD_BITSET:
      begin
        // value2 holds the mask of bits the job writes
        if ((value_q & ~value2_q) != 32'h00000000)
          err_num_d = `PJDC_E_BITSET;
      end
      pjdc_pkg::PJDC_CMD_BITCODE:
      begin
        if ((value_q & ~value2_q) != 32'h00000000)
          err_num_d = `PJDC_E_BITCODE;
      end
      pjdc_pkg::PJDC_CMD_CANCEL:
      begin
        // cancelling returns the actual value by the stored offset
        if (cfg_q.ssi && !cfg_q.rotary &&
            outside_limits(i_actual_pos - act_q, swl_lo_q, swl_hi_q,
                           32'h00000000))
          err_num_d = `PJDC_E_CANCEL;
      end
      pjdc_pkg::PJDC_CMD_SET_ACT,
      pjdc_pkg::PJDC_CMD_SET_FLY:
      begin
        if (!md_activated_q)
          err_num_d = `PJDC_E_NO_MD;
        else if (!cfg_q.synced)
          err_num_d = `PJDC_E_NO_SYNC;
        else if (out_of_range(value_q, cfg_q.coarse) ||
                 (cfg_q.rotary && bad_rotary(value_q, rot_end_q, 1'b1)))
          err_num_d = `PJDC_E_VAL36;
      end
      pjdc_pkg::PJDC_CMD_VAL36:
      begin
        if (out_of_range(value_q, cfg_q.coarse) ||
            (cfg_q.rotary && bad_rotary(value_q, rot_end_q, 1'b1)))
          err_num_d = `PJDC_E_VAL36;
      end
      pjdc_pkg::PJDC_CMD_SWITCH:
      begin
        if (!md_activated_q)
          err_num_d = `PJDC_E_NO_MD;
        else if (out_of_range(value_q, cfg_q.coarse) ||
                 out_of_range(value2_q, cfg_q.coarse))
          err_num_d = `PJDC_E_VAL37;
        else if (!($signed(value2_q) < $signed(value_q)))
          err_num_d = `PJDC_E_VAL37;
      end
      default:
      begin
        err_num_d = 8'h00;
      end
    endcase
  end

  // job staging registers, written freely by software
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      value_q <= 32'h00000000;
      value2_q <= 32'h00000000;
      cfg_q <= '0;
      rot_end_q <= `PJDC_RST_ROT_END;
      swl_lo_q <= `PJDC_RST_SWL_LO;
      swl_hi_q <= `PJDC_RST_SWL_HI;
    end
    else if (wr_en)
    begin
      if (i_paddr == `PJDC_OFF_VALUE)
        value_q <= i_pwdata;
      else if (i_paddr == `PJDC_OFF_VALUE2)
        value2_q <= i_pwdata;
      else if (i_paddr == `PJDC_OFF_CFG)
      begin
        // placed by name: a whole-word cast would put rotary on the msb
        cfg_q.rotary <= i_pwdata[`PJDC_CFG_ROTARY];
        cfg_q.coarse <= i_pwdata[`PJDC_CFG_COARSE];
        cfg_q.ssi <= i_pwdata[`PJDC_CFG_SSI];
        cfg_q.synced <= i_pwdata[`PJDC_CFG_SYNC];
        cfg_q.md_new <= i_pwdata[`PJDC_CFG_MD_NEW];
      end
      else if (i_paddr == `PJDC_OFF_ROT_END)
        rot_end_q <= i_pwdata;
      else if (i_paddr == `PJDC_OFF_SWL_LO)
        swl_lo_q <= i_pwdata;
      else if (i_paddr == `PJDC_OFF_SWL_HI)
        swl_hi_q <= i_pwdata;
    end
  end

  // accepted job values; a rejected job leaves them untouched
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      zero_ofs_q <= 32'h00000000;
      target_q <= 32'h00000000;
      coord_q <= 32'h00000000;
      bits_q <= 32'h00000000;
      sw_off_q <= 32'h00000000;
      sw_over_q <= 32'h00000000;
      act_q <= 32'h00000000;
      md_activated_q <= 1'b0;
    end
    else if (job_go && err_num_d == 8'h00)
    begin
      case (job_cmd)
        pjdc_pkg::PJDC_CMD_TARGET,
        pjdc_pkg::PJDC_CMD_INCR: target_q <= value_q;
        pjdc_pkg::PJDC_CMD_ZERO_OFS: zero_ofs_q <= value_q;
        pjdc_pkg::PJDC_CMD_COORD,
        pjdc_pkg::PJDC_CMD_REFPT: coord_q <= value_q;
        pjdc_pkg::PJDC_CMD_MD_ACT: md_activated_q <= 1'b1;
        pjdc_pkg::PJDC_CMD_BITSET,
        pjdc_pkg::PJDC_CMD_BITCODE: bits_q <= value_q;
        pjdc_pkg::PJDC_CMD_CANCEL: act_q <= 32'h00000000;
        pjdc_pkg::PJDC_CMD_SET_ACT,
        pjdc_pkg::PJDC_CMD_SET_FLY: act_q <= value_q - i_actual_pos;
        pjdc_pkg::PJDC_CMD_SWITCH:
        begin
          sw_over_q <= value_q;
          sw_off_q <= value2_q;
        end
        default: target_q <= target_q;
      endcase
    end
    else if (!i_md_active)
      md_activated_q <= md_activated_q & i_md_present;
  end

  // error number per job; class 4 for every data error
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      err_q <= '0;
    else if (job_go)
    begin
      err_q.err_num <= err_num_d;
      err_q.err_class <= (err_num_d != 8'h00) ? `PJDC_ERR_CLASS : 8'h00;
    end
  end

  // only operator errors abort motion; data errors never do
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      abort_q <= 1'b0;
    else
      abort_q <= i_operator_err & i_ctrl_change;
  end
  assign o_pos_abort = abort_q;

  // sticky events: job accepted, data error, operator abort
  assign irq_set = {abort_q, job_go & (err_num_d != 8'h00),
                    job_go & (err_num_d == 8'h00)};

  // set wins over a same-cycle clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      irq_stat_q <= 3'h0;
    else if (wr_en && i_paddr == `PJDC_OFF_IRQ_CLR)
      irq_stat_q <= (irq_stat_q & ~i_pwdata[2:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      irq_en_q <= 3'h0;
    else if (wr_en && i_paddr == `PJDC_OFF_IRQ_EN)
      irq_en_q <= i_pwdata[2:0];
  end
  // this is a plain event interrupt, not the diagnostic one
  assign o_irq = |(irq_stat_q & irq_en_q);

  // read mux; unmapped addresses answer zero with pslverr
  always_comb
  begin
    o_prdata = 32'h00000000;
    o_pslverr = 1'b0;
    if (i_paddr == `PJDC_OFF_CMD)
      o_prdata = 32'h00000000;
    else if (i_paddr == `PJDC_OFF_VALUE)
      o_prdata = value_q;
    else if (i_paddr == `PJDC_OFF_VALUE2)
      o_prdata = value2_q;
    else if (i_paddr == `PJDC_OFF_CFG)
    begin
      o_prdata[`PJDC_CFG_ROTARY] = cfg_q.rotary;
      o_prdata[`PJDC_CFG_COARSE] = cfg_q.coarse;
      o_prdata[`PJDC_CFG_SSI] = cfg_q.ssi;
      o_prdata[`PJDC_CFG_SYNC] = cfg_q.synced;
      o_prdata[`PJDC_CFG_MD_NEW] = cfg_q.md_new;
    end
    else if (i_paddr == `PJDC_OFF_ROT_END)
      o_prdata = rot_end_q;
    else if (i_paddr == `PJDC_OFF_SWL_LO)
      o_prdata = swl_lo_q;
    else if (i_paddr == `PJDC_OFF_SWL_HI)
      o_prdata = swl_hi_q;
    else if (i_paddr == `PJDC_OFF_ERR)
      o_prdata = {16'h0000, err_q};
    else if (i_paddr == `PJDC_OFF_IRQ_STAT)
      o_prdata = {29'h00000000, irq_stat_q};
    else if (i_paddr == `PJDC_OFF_IRQ_EN)
      o_prdata = {29'h00000000, irq_en_q};
    else if (i_paddr == `PJDC_OFF_IRQ_CLR)
      o_prdata = 32'h00000000;
    else if (i_paddr == `PJDC_OFF_ZERO_OFS)
      o_prdata = zero_ofs_q;
    else if (i_paddr == `PJDC_OFF_SWITCH)
      o_prdata = {sw_over_q[15:0], sw_off_q[15:0]};
    else if (i_paddr == `PJDC_OFF_SYS_STAT)
      o_prdata = {30'h00000000, abort_q, md_activated_q};
    else
      o_pslverr = i_psel & i_penable;
    if (!rd_en)
      o_prdata = 32'h00000000;
  end
endmodule : pjdc_checker
`default_nettype wire

// File: dv/pjdc_checker_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pjdc_defs.svh"
module pjdc_checker_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic i_md_present,
  input wire logic i_md_active,
  input wire logic i_operator_err,
  input wire logic i_ctrl_change,
  input wire logic o_pos_abort,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic wr_acc;
  logic rd_err;
  logic out_fine;
  logic [3:0] cmd_q;
  logic [31:0] val_q;
  logic [31:0] val2_q;
  logic [4:0] cfg_q;
  logic [15:0] err;
  // access decode and value range seen from the bus
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_err = i_psel && i_penable && !i_pwrite
    && i_paddr == `PJDC_OFF_ERR;
  assign err = o_prdata[15:0];
  assign out_fine = $signed(val_q) > `PJDC_RANGE_FINE
    || $signed(val_q) < -`PJDC_RANGE_FINE;
  // shadow of the job words so an error read is judged against its job
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      cmd_q <= 4'h0;
    else if (wr_acc && i_paddr == `PJDC_OFF_CMD)
      cmd_q <= i_pwdata[3:0];
    if (wr_acc && i_paddr == `PJDC_OFF_VALUE)
      val_q <= i_pwdata;
    if (wr_acc && i_paddr == `PJDC_OFF_VALUE2)
      val2_q <= i_pwdata;
    if (wr_acc && i_paddr == `PJDC_OFF_CFG)
      cfg_q <= i_pwdata[4:0];
  end
  chk_err_class:
    assert property (rd_err |-> o_prdata[31:16] == 16'h0 && (err == 16'h0
      || err[15:8] == `PJDC_ERR_CLASS && err[7:0] != 8'h0))
    else $error("error word malformed");
  chk_abort_cause:
    assert property (o_pos_abort |-> $past(i_operator_err && i_ctrl_change))
    else $error("abort without operator error");
  chk_abort_follow:
    assert property (i_operator_err && i_ctrl_change |=> o_pos_abort)
    else $error("operator error did not abort");
  chk_range_num:
    assert property (rd_err && i_md_active && cmd_q inside {4'h1, 4'hd}
      && !cfg_q[1] && out_fine
      |-> err == (cmd_q == 4'hd ? 16'h0424 : 16'h0406))
    else $error("out of range value accepted");
  chk_md_refuse:
    assert property (rd_err && i_md_active && !i_md_present
      && cmd_q == 4'h6 |-> err == 16'h0414)
    else $error("activation without new set accepted");
  chk_unused_bits:
    assert property (rd_err && i_md_active && cmd_q inside {4'h7, 4'h8}
      && |(val_q & ~val2_q) |-> err[7:0] == (cmd_q == 4'h7 ? 8'h1b : 8'h1d))
    else $error("stray bits accepted");
  chk_switch_order:
    assert property (rd_err && i_md_active && cmd_q == 4'hc
      && $signed(val2_q) >= $signed(val_q) |-> err == 16'h0425)
    else $error("switch differences misordered");
  chk_no_md:
    assert property (rd_err && !i_md_active && !i_md_present
      && cmd_q inside {[4'h1:4'h5], [4'ha:4'hc]} |-> err == 16'h046b)
    else $error("job without machine data accepted");
  chk_no_sync:
    assert property (rd_err && i_md_active && !cfg_q[3]
      && cmd_q inside {4'ha, 4'hb} |-> err == 16'h046c)
    else $error("set actual on unsynced axis");
  cover property (rd_err && err[15:8] == `PJDC_ERR_CLASS);
  cover property (o_pos_abort);
  cover property (o_irq);
endmodule : pjdc_checker_monitor
bind pjdc_checker pjdc_checker_monitor u_pjdc_checker_monitor (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .i_md_present(i_md_present),
  .i_md_active(i_md_active), .i_operator_err(i_operator_err),
  .i_ctrl_change(i_ctrl_change), .o_pos_abort(o_pos_abort),
  .o_irq(o_irq));
`default_nettype wire

// File: dv/pjdc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pjdc_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // bus idle from time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
  end
  // one transfer plus an idle cycle, so back-to-back calls never
  // assign psel twice in one time step
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic se);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= wd;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    do
      @(posedge i_ref_clk);
    while (i_pready !== 1'b1);
    rd = i_prdata;
    se = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata <= ~wd; // released data no longer shows the last word
    @(posedge i_ref_clk);
  endtask : xfer
endmodule : pjdc_cpu_model
`default_nettype wire

// File: dv/positioning_job_data_checker_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pjdc_defs.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module positioning_job_data_checker_bench;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic md_present, md_active, op_err, ctrl_chg, abort, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, actual_pos;
  int err_count;
  int checked;
  pjdc_checker u_pjdc_checker (.i_ref_clk(ref_clk), .i_rst(rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_md_present(md_present),
    .i_md_active(md_active), .i_operator_err(op_err),
    .i_ctrl_change(ctrl_chg), .i_actual_pos(actual_pos),
    .o_pos_abort(abort), .o_irq(irq));
  pjdc_cpu_model u_pjdc_cpu_model (.i_ref_clk(ref_clk),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata));
  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic se;
    u_pjdc_cpu_model.xfer(1'b1, a, d, r, se);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic se;
    u_pjdc_cpu_model.xfer(1'b0, a, 32'h0, r, se);
    `CHK($sformatf("reg_%h", a), e, r)
  endtask : rchk
  // job words first, command last, then the error word is read back
  task automatic job(input logic [31:0] cfg, v, v2, input logic [3:0] c,
    input logic [15:0] e);
    wr(`PJDC_OFF_VALUE, v);
    wr(`PJDC_OFF_VALUE2, v2);
    wr(`PJDC_OFF_CFG, cfg);
    wr(`PJDC_OFF_CMD, {28'h0, c});
    rchk(`PJDC_OFF_ERR, {16'h0, e});
  endtask : job
  task conclude;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // whole run is about 500 cycles; allow ample margin
  initial
  begin
    #200us;
    err_count++;
    conclude();
  end
  initial
  begin
    logic [31:0] r;
    logic se;
    err_count = 0;
    checked = 0;
    rst = 1'b1;
    md_present = 1'b1;
    md_active = 1'b1;
    op_err = 1'b0;
    ctrl_chg = 1'b0;
    actual_pos = 32'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rchk(12'h010, 32'h168);
    rchk(12'h014, 32'hfa0a1f00);
    rchk(12'h018, 32'h05f5e100);
    wr(12'h014, 32'hfffffc18);
    wr(12'h018, 32'h3e8);
    // jobs that need parameters are refused until machine data has been activated
    job(32'h18, 32'h0, 32'h0, 4'h6, 16'h0000);
    rchk(12'h034, 32'h1);
    job(32'h8, 32'h05f5e100, 32'h0, 4'h1, 16'h0000);
    job(32'h8, 32'h05f5e101, 32'h0, 4'h1, 16'h0406);
    `CHK("abort", 1'b0, abort)
    job(32'ha, 32'h05f5e101, 32'h0, 4'h2, 16'h0000);
    job(32'h9, 32'h168, 32'h0, 4'h1, 16'h0406);
    job(32'h9, 32'hffffffff, 32'h0, 4'h2, 16'h0406);
    job(32'h8, 32'h05f5e101, 32'h0, 4'h3, 16'h040a);
    job(32'h8, 32'h05f5e100, 32'h0, 4'h3, 16'h040a);
    job(32'h8, 32'h1f4, 32'h0, 4'h3, 16'h0000);
    job(32'h9, 32'h169, 32'h0, 4'h3, 16'h040a);
    rchk(12'h02c, 32'h1f4);
    job(32'h8, 32'h1f5, 32'h0, 4'h4, 16'h040b);
    job(32'h8, 32'hfffffa23, 32'h0, 4'h5, 16'h040c);
    job(32'h9, 32'h169, 32'h0, 4'h4, 16'h040b);
    job(32'h9, 32'h168, 32'h0, 4'h5, 16'h0000);
    job(32'h18, 32'h0, 32'h0, 4'h6, 16'h0000);
    md_present <= 1'b0;
    job(32'h18, 32'h0, 32'h0, 4'h6, 16'h0414);
    job(32'h8, 32'h10, 32'hf, 4'h7, 16'h041b);
    job(32'h8, 32'h100, 32'hff, 4'h8, 16'h041d);
    job(32'h8, 32'hf, 32'hf, 4'h7, 16'h0000);
    actual_pos <= 32'd1501;
    job(32'hc, 32'h0, 32'h0, 4'h9, 16'h0422);
    job(32'h0, 32'h0, 32'h0, 4'ha, 16'h046c);
    job(32'h0, 32'h0, 32'h0, 4'hb, 16'h046c);
    job(32'h8, 32'h64, 32'h64, 4'hc, 16'h0425);
    job(32'h8, 32'h64, 32'h63, 4'hc, 16'h0000);
    job(32'h8, 32'h05f5e101, 32'h0, 4'hc, 16'h0425);
    rchk(12'h030, 32'h00640063);
    job(32'h8, 32'h05f5e101, 32'h0, 4'hd, 16'h0424);
    job(32'h9, 32'h168, 32'h0, 4'hd, 16'h0424);
    // sticky error bit raises the line once enabled, clear drops it
    rchk(12'h020, 32'h3);
    wr(12'h024, 32'h2);
    `CHK("irq", 1'b1, irq)
    wr(12'h028, 32'h7);
    `CHK("irq", 1'b0, irq)
    rchk(12'h020, 32'h0);
    op_err <= 1'b1;
    ctrl_chg <= 1'b1;
    @(posedge ref_clk);
    op_err <= 1'b0;
    ctrl_chg <= 1'b0;
    #1 `CHK("abort", 1'b1, abort)
    @(posedge ref_clk);
    rchk(12'h020, 32'h4);
    `CHK("irq", 1'b0, irq)
    u_pjdc_cpu_model.xfer(1'b0, 12'h040, 32'h0, r, se);
    `CHK("slverr", 1'b1, se)
    md_active <= 1'b0;
    job(32'h8, 32'h0, 32'h0, 4'h1, 16'h046b);
    rchk(12'h034, 32'h0);
    conclude();
  end
endmodule : positioning_job_data_checker_bench
`default_nettype wire
